// *** rtl/asrtc_core.sv ***
// Purpose: Full-duplex asynchronous serial receiver and transmitter
// Assumes: Register file port and timer pulse on the same clock as the core
// Notes:   Transmit writes pass a small FIFO before loading the shifter
//
// Notes on behaviour
// - After reset and each character, receive shifter is ones, shift clock stopped.
// - Serial input passes two clocked flip-flops before any receive logic.
// - Idle receiver arms its bit timing on a high-to-low input transition.
// - Receiver counts timer pulses modulo sixteen, first sample at count eight.
// - Start bit rechecked low at mid-bit, else receiver returns to idle.
// - After a good start bit, one data bit is taken every sixteen pulses.
// - Completed character: receive request raised, shifter ones, back to start search.
// - Receive buffer is single, a new character overwrites, no overrun flag.
// - No framing check; the synchronised input level stays readable always.
// - With parity on, received bit seven becomes the odd-parity error flag.
// - Odd parity only, enabled by mode bit seven; off passes all eight bits.
// - After reset and each character the transmitter holds its output high.
// - A write to the data buffer location loads the transmitter, but only while serial mode is on.
// - A buffer write clears the transmit divider, shifts follow sixteen pulses later.
// - Transmitter sends low start bit, eight buffered bits, two high stop bits.
// - After the second stop bit, output marks and transmit request is raised.
// - With parity on, outgoing bit seven is replaced by an odd parity bit.
// - A write during transmission aborts it and starts a fresh start bit.
// - After reset, buffer contents are zero, serial mode and parity off.
// - Mode bit six enables serial mode; timer pulses then feed the dividers.
`timescale 1ns/1ps
`include "asrtc_defines.svh"

module asrtc_core
   import asrtc_pkg::*;
#(
   parameter int TX_FIFO_DEPTH = 16
)
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Register file access
   input  wire logic [7:0] regAddr,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [7:0] regWrData,
   output logic      [7:0] regRdData,
   output logic            txWriteReady,
   // Bit-rate timer
   input  wire logic       timerEoc,
   output logic            timerIrqPulse,
   // Serial pins
   input  wire logic       serialInputPin,
   output logic            serialOutput,
   output logic            serialOutputEn_n,
   output logic            serialPinLevel,
   // Interrupt requests
   output logic            receiveInterruptRequest,
   output logic            transmitInterruptRequest
);

   asrtc_state_t stateReg;
   asrtc_state_t stateNext;

   logic       rxLevel;
   logic       fifoInReady;
   logic       fifoOutValid;
   logic [7:0] fifoOutData;
   logic       fifoOutReady;
   logic       fifoPush;
   logic       txLoad;
   logic       rxFall;
   logic       rxSample;
   logic       rxDone;
   logic       txShift;
   logic [3:0] rxDivInc;
   logic [3:0] txDivInc;
   logic [7:0] rxChar;
   logic [7:0] txChar;

   asrtc_sync u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .pinIn    (serialInputPin),
      .levelOut (rxLevel)
   );

   // Only buffer writes while serial mode is on
   assign fifoPush = regWrite && (regAddr == `ASRTC_ADDR_DATA_BUF) && stateReg.serialEn;

   // Drain pauses one cycle after each load, so bursts of writes queue
   assign fifoOutReady = !stateReg.txLoaded && stateReg.serialEn;

   asrtc_fifo #(
      .WIDTH (8),
      .DEPTH (TX_FIFO_DEPTH)
   ) u_txfifo (
      .clock    (clock),
      .rst_n    (rst_n),
      .inValid  (fifoPush),
      .inData   (regWrData),
      .inReady  (fifoInReady),
      .outValid (fifoOutValid),
      .outData  (fifoOutData),
      .outReady (fifoOutReady)
   );

   always_comb
   begin
      stateNext = stateReg;
      txLoad    = fifoOutValid && fifoOutReady && stateReg.serialEn;
      rxDivInc  = stateReg.rxDiv + `ASRTC_DIV_ONE;
      txDivInc  = stateReg.txDiv + `ASRTC_DIV_ONE;
      rxFall    = stateReg.pinLevel && !rxLevel;
      rxSample  = (stateReg.rxState == ASRTC_RX_RUN) && timerEoc
                  && (rxDivInc == `ASRTC_RX_SAMPLE_AT);
      rxDone    = rxSample && (stateReg.rxBitIdx == `ASRTC_RX_LAST_BIT);
      txShift   = (stateReg.txState == ASRTC_TX_SEND) && timerEoc
                  && (txDivInc == `ASRTC_DIV_ZERO);
      rxChar    = {rxLevel, stateReg.rxShift[7:1]};
      txChar    = fifoOutData;

      // Single-cycle outputs default low
      stateNext.rxIrq    = 1'b0;
      stateNext.txIrq    = 1'b0;
      stateNext.txLoaded = txLoad;

      // Level seen by software and by the edge detector
      stateNext.pinLevel = rxLevel;

      // Mode register is write-only
      if (regWrite && (regAddr == `ASRTC_ADDR_PORT3_MODE))
      begin
         stateNext.serialEn = regWrData[`ASRTC_P3M_SERIAL_BIT];
         stateNext.parityEn = regWrData[`ASRTC_P3M_PARITY_BIT];
      end

      // Timer interrupt only while the timer is not the bit-rate source
      stateNext.timerIrq = timerEoc && !stateReg.serialEn;

      // Reads return the receive buffer; other locations read zero
      if (regRead && (regAddr == `ASRTC_ADDR_DATA_BUF))
      begin
         stateNext.rdData = stateReg.rxBuf;
      end
      else
      begin
         stateNext.rdData = `ASRTC_BYTE_ZERO;
      end

      // Receiver
      case (stateReg.rxState)
         ASRTC_RX_IDLE:
         begin
            stateNext.rxShift = `ASRTC_SHIFT_ONES;
            if (stateReg.serialEn && rxFall)
            begin
               stateNext.rxState  = ASRTC_RX_RUN;
               stateNext.rxDiv    = `ASRTC_DIV_ZERO;
               stateNext.rxBitIdx = `ASRTC_DIV_ZERO;
            end
         end
         ASRTC_RX_RUN:
         begin
            if (timerEoc)
            begin
               stateNext.rxDiv = rxDivInc;
            end
            if (rxSample)
            begin
               if (stateReg.rxBitIdx == `ASRTC_DIV_ZERO)
               begin
                  // False start: glitch shorter than half a bit
                  if (rxLevel)
                  begin
                     stateNext.rxState = ASRTC_RX_IDLE;
                  end
                  else
                  begin
                     stateNext.rxBitIdx = `ASRTC_DIV_ONE;
                  end
               end
               else
               begin
                  stateNext.rxShift  = rxChar;
                  stateNext.rxBitIdx = stateReg.rxBitIdx + `ASRTC_DIV_ONE;
               end
            end
            // Stop bit is not checked; software may sample the pin level
            if (rxDone)
            begin
               stateNext.rxBuf = rxChar;
               if (stateReg.parityEn)
               begin
                  stateNext.rxBuf[`ASRTC_PARITY_BIT] = ~^rxChar;
               end
               stateNext.rxIrq   = 1'b1;
               stateNext.rxShift = `ASRTC_SHIFT_ONES;
               stateNext.rxState = ASRTC_RX_IDLE;
            end
         end
         default:
         begin
            stateNext.rxState = ASRTC_RX_IDLE;
         end
      endcase

      // Transmitter
      case (stateReg.txState)
         ASRTC_TX_IDLE:
         begin
            stateNext.txFrame = `ASRTC_FRAME_MARK;
         end
         ASRTC_TX_SEND:
         begin
            if (timerEoc)
            begin
               stateNext.txDiv = txDivInc;
            end
            if (txShift)
            begin
               if (stateReg.txBitsLeft == `ASRTC_DIV_ONE)
               begin
                  stateNext.txState = ASRTC_TX_IDLE;
                  stateNext.txFrame = `ASRTC_FRAME_MARK;
                  stateNext.txIrq   = 1'b1;
               end
               else
               begin
                  stateNext.txFrame    = {1'b1, stateReg.txFrame[10:1]};
                  stateNext.txBitsLeft = stateReg.txBitsLeft - `ASRTC_DIV_ONE;
               end
            end
         end
         default:
         begin
            stateNext.txState = ASRTC_TX_IDLE;
         end
      endcase

      // A load wins over any frame in flight
      if (txLoad)
      begin
         if (stateReg.parityEn)
         begin
            txChar[`ASRTC_PARITY_BIT] = ~^fifoOutData[6:0];
         end
         stateNext.txState    = ASRTC_TX_SEND;
         stateNext.txDiv      = `ASRTC_DIV_ZERO;
         stateNext.txBitsLeft = `ASRTC_TX_FRAME_BITS;
         stateNext.txFrame    = {2'b11, txChar, 1'b0};
      end

      // Serial mode off forces both paths idle
      if (!stateReg.serialEn)
      begin
         stateNext.rxState = ASRTC_RX_IDLE;
         stateNext.txState = ASRTC_TX_IDLE;
         stateNext.txFrame = `ASRTC_FRAME_MARK;
         stateNext.rxIrq   = 1'b0;
         stateNext.txIrq   = 1'b0;
      end

      stateNext.txOut     = stateNext.txFrame[0];
      stateNext.txOutEn_n = !stateNext.serialEn;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         stateReg <= '{
            serialEn:   1'b0,
            parityEn:   1'b0,
            rxState:    ASRTC_RX_IDLE,
            rxDiv:      `ASRTC_DIV_ZERO,
            rxBitIdx:   `ASRTC_DIV_ZERO,
            rxShift:    `ASRTC_SHIFT_ONES,
            rxBuf:      `ASRTC_BYTE_ZERO,
            txState:    ASRTC_TX_IDLE,
            txDiv:      `ASRTC_DIV_ZERO,
            txBitsLeft: `ASRTC_DIV_ZERO,
            txFrame:    `ASRTC_FRAME_MARK,
            txLoaded:   1'b0,
            rdData:     `ASRTC_BYTE_ZERO,
            rxIrq:      1'b0,
            txIrq:      1'b0,
            timerIrq:   1'b0,
            txOut:      1'b1,
            txOutEn_n:  1'b1,
            pinLevel:   1'b1
         };
      end
      else
      begin
         stateReg <= stateNext;
      end
   end

   assign regRdData                = stateReg.rdData;
   assign txWriteReady             = fifoInReady;
   assign timerIrqPulse            = stateReg.timerIrq;
   assign serialOutput             = stateReg.txOut;
   assign serialOutputEn_n         = stateReg.txOutEn_n;
   assign serialPinLevel           = stateReg.pinLevel;
   assign receiveInterruptRequest  = stateReg.rxIrq;
   assign transmitInterruptRequest = stateReg.txIrq;

   tx_idle_marks_a : assert property (@(posedge clock) disable iff (!rst_n)
      (stateReg.txState == ASRTC_TX_IDLE) |-> serialOutput)
      else $error("idle transmitter not marking");

   mode_off_quiet_a : assert property (@(posedge clock) disable iff (!rst_n)
      !stateReg.serialEn [*2] |-> serialOutputEn_n && !receiveInterruptRequest
                                  && !transmitInterruptRequest)
      else $error("serial logic active with serial mode off");

   tx_load_start_a : assert property (@(posedge clock) disable iff (!rst_n)
      txLoad |=> (stateReg.txState == ASRTC_TX_SEND) && !serialOutput
                 && (stateReg.txDiv == `ASRTC_DIV_ZERO))
      else $error("buffer load did not start a fresh start bit");

   tx_done_irq_a : assert property (@(posedge clock) disable iff (!rst_n)
      (txShift && (stateReg.txBitsLeft == `ASRTC_DIV_ONE) && !txLoad && stateReg.serialEn)
      |=> transmitInterruptRequest && serialOutput ##1 !transmitInterruptRequest)
      else $error("transmit end not flagged with marking output");

   rx_edge_arms_a : assert property (@(posedge clock) disable iff (!rst_n)
      ((stateReg.rxState == ASRTC_RX_IDLE) && stateReg.serialEn && rxFall)
      |=> (stateReg.rxState == ASRTC_RX_RUN) && (stateReg.rxDiv == `ASRTC_DIV_ZERO))
      else $error("start edge did not arm the receiver");

   rx_false_start_a : assert property (@(posedge clock) disable iff (!rst_n)
      (rxSample && (stateReg.rxBitIdx == `ASRTC_DIV_ZERO) && rxLevel)
      |=> (stateReg.rxState == ASRTC_RX_IDLE) && !receiveInterruptRequest)
      else $error("false start bit not rejected");

   rx_done_reset_a : assert property (@(posedge clock) disable iff (!rst_n)
      (rxDone && stateReg.serialEn) |=> receiveInterruptRequest
         && (stateReg.rxShift == `ASRTC_SHIFT_ONES)
         && (stateReg.rxState == ASRTC_RX_IDLE))
      else $error("completed character not handled");

   rx_parity_flag_a : assert property (@(posedge clock) disable iff (!rst_n)
      (rxDone && stateReg.serialEn && stateReg.parityEn)
      |=> stateReg.rxBuf[`ASRTC_PARITY_BIT] == ~^$past(rxChar))
      else $error("parity error flag wrong");

   timer_irq_gate_a : assert property (@(posedge clock) disable iff (!rst_n)
      timerEoc |=> (timerIrqPulse == !$past(stateReg.serialEn)))
      else $error("timer interrupt not gated by serial mode");

endmodule

// *** rtl/asrtc_defines.svh ***
// Purpose: Named constants of the serial receiver/transmitter core
// Assumes: Included by bare name from the core, synchroniser and FIFO files
// Notes:   Addresses are register file locations
`ifndef ASRTC_DEFINES_SVH
`define ASRTC_DEFINES_SVH

// Register file locations
`define ASRTC_ADDR_DATA_BUF     8'hf0
`define ASRTC_ADDR_PORT3_MODE   8'hf7

// Port 3 mode fields
`define ASRTC_P3M_SERIAL_BIT    6
`define ASRTC_P3M_PARITY_BIT    7

// Bit timing in timer pulses
`define ASRTC_DIV_ONE           4'h1
`define ASRTC_DIV_ZERO          4'h0
`define ASRTC_RX_SAMPLE_AT      4'h8
`define ASRTC_RX_LAST_BIT       4'h8
`define ASRTC_TX_FRAME_BITS     4'hb

// Reset and idle values
`define ASRTC_SHIFT_ONES        8'hff
`define ASRTC_BYTE_ZERO         8'h00
`define ASRTC_FRAME_MARK        11'h7ff
`define ASRTC_PARITY_BIT        7

`endif

// *** rtl/asrtc_pkg.sv ***
// Purpose: Types shared by the serial core files
// Assumes: Nothing beyond SystemVerilog
// Notes:   State vector of the core is one packed struct
package asrtc_pkg;

   typedef enum logic [0:0] {
      ASRTC_RX_IDLE = 1'b0,
      ASRTC_RX_RUN  = 1'b1
   } asrtc_rx_state_t;

   typedef enum logic [0:0] {
      ASRTC_TX_IDLE = 1'b0,
      ASRTC_TX_SEND = 1'b1
   } asrtc_tx_state_t;

   typedef struct packed {
      logic            serialEn;
      logic            parityEn;
      asrtc_rx_state_t rxState;
      logic [3:0]      rxDiv;
      logic [3:0]      rxBitIdx;
      logic [7:0]      rxShift;
      logic [7:0]      rxBuf;
      asrtc_tx_state_t txState;
      logic [3:0]      txDiv;
      logic [3:0]      txBitsLeft;
      logic [10:0]     txFrame;
      logic            txLoaded;
      logic [7:0]      rdData;
      logic            rxIrq;
      logic            txIrq;
      logic            timerIrq;
      logic            txOut;
      logic            txOutEn_n;
      logic            pinLevel;
   } asrtc_state_t;

endpackage

// *** rtl/asrtc_sync.sv ***
// Purpose: Two flip-flop synchroniser for the serial input pin
// Assumes: Pin idles high, so both stages reset to one
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`include "asrtc_defines.svh"

module asrtc_sync
   import asrtc_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Asynchronous pin and its synchronised level
   input  wire logic pinIn,
   output logic      levelOut
);

   typedef struct packed {
      logic stage1;
      logic stage2;
   } asrtc_sync_t;

   asrtc_sync_t syncReg;
   asrtc_sync_t syncNext;

   always_comb
   begin
      syncNext        = syncReg;
      syncNext.stage1 = pinIn;
      syncNext.stage2 = syncReg.stage1;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         syncReg <= '{stage1: 1'b1, stage2: 1'b1};
      end
      else
      begin
         syncReg <= syncNext;
      end
   end

   assign levelOut = syncReg.stage2;

endmodule

// *** rtl/asrtc_fifo.sv ***
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH of at least two
// Notes:   inReady is registered; it drops when the FIFO is full
`timescale 1ns/1ps
`include "asrtc_defines.svh"

module asrtc_fifo
   import asrtc_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   // Drain side
   output logic                  outValid,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wrPtr;
      logic [PW-1:0]               rdPtr;
      logic [CW-1:0]               count;
      logic                        ready;
   } asrtc_fifo_t;

   asrtc_fifo_t fifoReg;
   asrtc_fifo_t fifoNext;
   logic        doPush;
   logic        doPop;

   always_comb
   begin
      fifoNext = fifoReg;
      doPush   = inValid && fifoReg.ready;
      doPop    = outReady && (fifoReg.count != '0);
      if (doPush)
      begin
         fifoNext.mem[fifoReg.wrPtr] = inData;
         fifoNext.wrPtr = (fifoReg.wrPtr == LAST) ? '0 : fifoReg.wrPtr + 1'b1;
      end
      if (doPop)
      begin
         fifoNext.rdPtr = (fifoReg.rdPtr == LAST) ? '0 : fifoReg.rdPtr + 1'b1;
      end
      if (doPush && !doPop)
      begin
         fifoNext.count = fifoReg.count + 1'b1;
      end
      else if (doPop && !doPush)
      begin
         fifoNext.count = fifoReg.count - 1'b1;
      end
      fifoNext.ready = (fifoNext.count != FULL);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         fifoReg <= '{mem: '0, wrPtr: '0, rdPtr: '0, count: '0, ready: 1'b1};
      end
      else
      begin
         fifoReg <= fifoNext;
      end
   end

   assign inReady  = fifoReg.ready;
   assign outValid = (fifoReg.count != '0);
   assign outData  = fifoReg.mem[fifoReg.rdPtr];

   full_blocks_a : assert property (@(posedge clock) disable iff (!rst_n)
      (fifoReg.count == FULL) |-> !inReady ##1 (fifoReg.count <= FULL))
      else $error("fifo accepts data while full");

endmodule

// *** tb/asrtc_remote_model.sv ***
// Purpose: Remote serial station facing the core's pins
// Assumes: Bit time is sixteen timer pulses, pulses sampled on rising clock
// Notes:   Sends one stop bit only, the least the receiver must accept
`timescale 1ns/1ps

module asrtc_remote_model
(
   // Clock and bit timing
   input  wire logic clock,
   input  wire logic timerEoc,
   // Line towards the core
   output logic      serialInputPin,
   // Line from the core, pull-up resolved
   input  wire logic serialOutput
);
   logic [7:0] rxq[$];
   logic [7:0] got;
   logic [9:0] bits;

   initial serialInputPin = 1'b1;

   task automatic pulses(input int n);
      repeat (n)
      begin
         do @(posedge clock); while (timerEoc !== 1'b1);
      end
   endtask

   // Start, eight bits LSB first, single stop bit
   task automatic send(input logic [7:0] b);
      bits = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(negedge clock) serialInputPin = bits[i];
         pulses(16);
      end
   endtask

   // Short low pulse, gone before mid-bit
   task automatic glitch();
      @(negedge clock) serialInputPin = 1'b0;
      pulses(4);
      @(negedge clock) serialInputPin = 1'b1;
      pulses(20);
   endtask

   initial
   forever
   begin
      @(posedge clock);
      if (serialOutput === 1'b0)
      begin
         pulses(8);
         if (serialOutput === 1'b0)
         begin
            for (int i = 0; i < 8; i++)
            begin
               pulses(16);
               got[i] = serialOutput;
            end
            rxq.push_back(got);
         end
         while (serialOutput !== 1'b1) @(posedge clock);
      end
   end
endmodule

// *** tb/tb.sv ***
// Purpose: Self-checking bench of the serial core
// Assumes: Timer pulse every fourth clock
// Notes:   Remote model decodes what the core sends
`timescale 1ns/1ps

module tb;
   import asrtc_pkg::*;
   logic       clock, rst_n, regWrite, regRead, timerEoc, serialInputPin;
   logic [7:0] regAddr, regWrData, regRdData, b, got;
   logic       txWriteReady, timerIrqPulse, serialOutput, serialOutputEn_n;
   logic       serialPinLevel, receiveInterruptRequest, transmitInterruptRequest;
   logic       par;
   int         fails, check_count, tick, rxCount, n;
   wire        txLine = serialOutputEn_n ? 1'b1 : serialOutput;

   asrtc_core #(
      .TX_FIFO_DEPTH (16)
   ) asrtc_core_i (
      .clock                    (clock),
      .rst_n                    (rst_n),
      .regAddr                  (regAddr),
      .regWrite                 (regWrite),
      .regRead                  (regRead),
      .regWrData                (regWrData),
      .regRdData                (regRdData),
      .txWriteReady             (txWriteReady),
      .timerEoc                 (timerEoc),
      .timerIrqPulse            (timerIrqPulse),
      .serialInputPin           (serialInputPin),
      .serialOutput             (serialOutput),
      .serialOutputEn_n         (serialOutputEn_n),
      .serialPinLevel           (serialPinLevel),
      .receiveInterruptRequest  (receiveInterruptRequest),
      .transmitInterruptRequest (transmitInterruptRequest)
   );
   asrtc_remote_model asrtc_remote_model_i (
      .clock          (clock),
      .timerEoc       (timerEoc),
      .serialInputPin (serialInputPin),
      .serialOutput   (txLine)
   );

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   always @(negedge clock)
   begin
      tick <= tick + 1;
      timerEoc <= (tick % 4 == 3);
   end

   always @(negedge clock)
      if (receiveInterruptRequest === 1'b1) rxCount++;

   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim();
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge clock);
      regWrite = 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clock);
      // Read data stands for one cycle only
      regRead = 1'b0;
      d = regRdData;
   endtask

   // Requests last one cycle, so poll every edge
   task waitReq(input logic tx);
      n = 0;
      while ((tx ? transmitInterruptRequest : receiveInterruptRequest) !== 1'b1)
      begin
         @(negedge clock);
         n++;
         if (n > 3000)
         begin
            fails++;
            $display("MISMATCH %0t request timeout", $time);
            end_sim();
         end
      end
      @(negedge clock);
   endtask

   function automatic logic [7:0] txExp(input logic [7:0] d, input logic p);
      return p ? {~^d[6:0], d[6:0]} : d;
   endfunction

   function automatic logic [7:0] rxExp(input logic [7:0] d, input logic p);
      return p ? {~^d, d[6:0]} : d;
   endfunction

   initial
   begin
      repeat (100000) @(posedge clock);
      fails++;
      $display("MISMATCH %0t run timeout", $time);
      end_sim();
   end

   initial
   begin
      {regAddr, regWrData, regWrite, regRead, rst_n} = '0;
      void'($urandom(32'h0813));
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      check(serialOutput, 8'h01);
      check(serialOutputEn_n, 8'h01);
      check(transmitInterruptRequest, 8'h00);
      check(txWriteReady, 8'h01);
      check(serialPinLevel, 8'h01);
      for (n = 0; n < 8 && timerIrqPulse !== 1'b1; n++) @(negedge clock);
      check(timerIrqPulse, 8'h01);
      wr(8'hf0, 8'h00);
      repeat (80) @(negedge clock);
      check(serialOutput, 8'h01);
      wr(8'hf7, 8'h40);
      @(negedge clock);
      check(serialOutputEn_n, 8'h00);
      fork
         asrtc_remote_model_i.glitch();
         begin
            repeat (8) @(negedge clock);
            check(serialPinLevel, 8'h00);
         end
      join
      check(8'(rxCount), 8'h00);
      for (int k = 0; k < 12; k++)
      begin
         par = (k >= 6);
         if (k == 6) wr(8'hf7, 8'hc0);
         b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : (k == 7) ? 8'h80 : 8'($urandom);
         fork
            asrtc_remote_model_i.send(b);
            waitReq(1'b0);
         join
         rd(8'hf0, got);
         check(got, rxExp(b, par));
         wr(8'hf0, b);
         waitReq(1'b1);
         check(txLine, 8'h01);
         check(8'(asrtc_remote_model_i.rxq.size()), 8'h01);
         check(asrtc_remote_model_i.rxq.pop_front(), txExp(b, par));
      end
      asrtc_remote_model_i.send(8'h5a);
      asrtc_remote_model_i.send(8'ha5);
      rd(8'hf0, got);
      check(got, rxExp(8'ha5, 1'b1));
      wr(8'hf0, 8'hff);
      repeat (160) @(negedge clock);
      check(serialOutput, 8'h01);
      wr(8'hf0, 8'h00);
      repeat (3) @(negedge clock);
      check(serialOutput, 8'h00);
      waitReq(1'b1);
      repeat (100) @(negedge clock);
      asrtc_remote_model_i.rxq.delete();
      end_sim();
   end
endmodule
